// >>> nvac_ctrl.sv
// Nonvolatile byte access controller: registers, sequencer and array
//
// Summary of operation
// - 64 byte store, one byte per operation
// - Six-bit address field, cleared at reset
// - Address bits 7 and 6 read zero
// - Eight-bit data register, cleared at reset
// - Address and data registers in sector 0
// - Control register at 40H in sector 1
// - Write enable bit 3; clear blocks writes
// - Bit 2 starts write, cleared when done
// - Write start ignored unless enable set before
// - Read enable bit 1; clear blocks reads
// - Bit 0 starts read, cleared when done
// - Read start ignored unless enable set before
// - Control bits 7 to 4 read zero
// - Fetched byte held until next operation
// - Write timed by four slow timer ticks sampled on clk_sys
// - Write end sets sticky flag, software clears
`timescale 1ns/100ps
`default_nettype none

module nvac_ctrl
  import nvac_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          reset_n,
  input  wire nvac_sfr_req_t sfr_req,
  input  wire logic          slow_tick,
  input  wire logic          done_clr,
  output logic [7:0]         sfr_rdata_q,
  output logic               write_done_flag_q,
  output logic               busy_q
);

  nvac_regs_t regs_q;
  nvac_regs_t regs_d;

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_reg(input nvac_regs_t r, input logic [8:0] loc);
    logic [7:0] v;
    v = 8'h00;
    case (loc)
      NVAC_ADDR_LOC: v = {2'b00, r.addr};
      NVAC_DATA_LOC: v = r.data;
      NVAC_CTRL_LOC: v = {4'h0, r.ctrl};
      default:       v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    regs_d       = regs_q;
    regs_d.rdata = read_reg(regs_q, sfr_req.loc);

    // Software writes
    if (sfr_req.we) begin
      case (sfr_req.loc)
        NVAC_ADDR_LOC: begin
          regs_d.addr = sfr_req.wdata[NVAC_AW-1:0];
        end
        NVAC_DATA_LOC: begin
          regs_d.data = sfr_req.wdata;
        end
        NVAC_CTRL_LOC: begin
          regs_d.ctrl[NVAC_CB_WEN] = sfr_req.wdata[NVAC_CB_WEN];
          regs_d.ctrl[NVAC_CB_REN] = sfr_req.wdata[NVAC_CB_REN];
          // Start only when enable was already set; write wins a tie
          if (sfr_req.wdata[NVAC_CB_WGO] && regs_q.ctrl[NVAC_CB_WEN]
              && regs_q.st == NVAC_IDLE) begin
            regs_d.ctrl[NVAC_CB_WGO] = 1'b1;
          end else if (sfr_req.wdata[NVAC_CB_RGO] && regs_q.ctrl[NVAC_CB_REN]
                       && regs_q.st == NVAC_IDLE && !regs_q.ctrl[NVAC_CB_WGO]) begin
            regs_d.ctrl[NVAC_CB_RGO] = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Flag clear first so a same-cycle set wins
    if (done_clr) begin
      regs_d.done = 1'b0;
    end

    // Sequencer
    case (regs_q.st)
      NVAC_IDLE: begin
        regs_d.cnt = 4'h0;
        if (regs_q.ctrl[NVAC_CB_WGO]) begin
          regs_d.st = NVAC_WRITE;
        end else if (regs_q.ctrl[NVAC_CB_RGO]) begin
          regs_d.st = NVAC_READ;
        end
      end
      NVAC_READ: begin
        regs_d.cnt = regs_q.cnt + 4'h1;
        if (regs_q.cnt == NVAC_RD_CYC - 4'h1) begin
          regs_d.data             = regs_q.mem[regs_q.addr];
          regs_d.ctrl[NVAC_CB_RGO] = 1'b0;
          regs_d.st               = NVAC_IDLE;
        end
      end
      NVAC_WRITE: begin
        if (slow_tick) begin
          regs_d.cnt = regs_q.cnt + 4'h1;
          if (regs_q.cnt == NVAC_WR_TICKS - 4'h1) begin
            regs_d.mem[regs_q.addr]  = regs_q.data;
            regs_d.ctrl[NVAC_CB_WGO] = 1'b0;
            regs_d.done              = 1'b1;
            regs_d.st                = NVAC_IDLE;
          end
        end
      end
      default: begin
        regs_d.st = NVAC_IDLE;
      end
    endcase

    // Busy registered so the output comes straight from a flop
    regs_d.busy = (regs_d.st != NVAC_IDLE);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      regs_q       <= '0;
      regs_q.mem   <= {NVAC_DEPTH{NVAC_CELL_RST}};
      regs_q.st    <= NVAC_IDLE;
      regs_q.addr  <= NVAC_ADDR_RST;
      regs_q.data  <= NVAC_DATA_RST;
      regs_q.ctrl  <= NVAC_CTRL_RST;
    end else begin
      regs_q <= regs_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sfr_rdata_q       = regs_q.rdata;
  assign write_done_flag_q = regs_q.done;
  assign busy_q            = regs_q.busy;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_addr_upper_zero: assert property (
    $past(sfr_req.loc) == NVAC_ADDR_LOC |-> sfr_rdata_q[7:6] == 2'b00)
    else $error("address register upper bits not zero");

  a_ctrl_upper_zero: assert property (
    $past(sfr_req.loc) == NVAC_CTRL_LOC |-> sfr_rdata_q[7:4] == 4'h0)
    else $error("control register upper bits not zero");

  a_write_needs_enable: assert property (
    sfr_req.we && sfr_req.loc == NVAC_CTRL_LOC && !regs_q.ctrl[NVAC_CB_WEN]
    && !regs_q.ctrl[NVAC_CB_WGO] |=> !regs_q.ctrl[NVAC_CB_WGO])
    else $error("write started without prior enable");

  a_read_needs_enable: assert property (
    sfr_req.we && sfr_req.loc == NVAC_CTRL_LOC && !regs_q.ctrl[NVAC_CB_REN]
    && !regs_q.ctrl[NVAC_CB_RGO] |=> !regs_q.ctrl[NVAC_CB_RGO])
    else $error("read started without prior enable");

  a_read_fixed_len: assert property (
    $rose(regs_q.ctrl[NVAC_CB_RGO]) |-> regs_q.ctrl[NVAC_CB_RGO][*3]
    ##1 !regs_q.ctrl[NVAC_CB_RGO])
    else $error("read cycle length wrong");

  a_read_data_load: assert property (
    $fell(regs_q.ctrl[NVAC_CB_RGO]) |-> regs_q.data == regs_q.mem[regs_q.addr])
    else $error("read data not loaded");

  a_write_done_set: assert property (
    $fell(regs_q.ctrl[NVAC_CB_WGO]) |-> write_done_flag_q
    && regs_q.mem[regs_q.addr] == regs_q.data)
    else $error("write end without flag or data");

  a_done_sticky: assert property (
    write_done_flag_q && !done_clr |=> write_done_flag_q)
    else $error("done flag dropped without clear");

  a_mem_guarded: assert property (
    regs_q.st != NVAC_WRITE |=> $stable(regs_q.mem))
    else $error("array changed outside a write");

  a_write_start_guard: assert property (
    !regs_q.ctrl[NVAC_CB_WEN] && !regs_q.ctrl[NVAC_CB_WGO] |=> !regs_q.ctrl[NVAC_CB_WGO])
    else $error("write start set while write enable clear");

  a_read_start_guard: assert property (
    !regs_q.ctrl[NVAC_CB_REN] && !regs_q.ctrl[NVAC_CB_RGO] |=> !regs_q.ctrl[NVAC_CB_RGO])
    else $error("read start set while read enable clear");

  a_write_on_tick: assert property (
    $fell(regs_q.ctrl[NVAC_CB_WGO]) |-> $past(slow_tick))
    else $error("write ended without a slow timer tick");

  a_data_held: assert property (
    regs_q.st == NVAC_IDLE && !(sfr_req.we && sfr_req.loc == NVAC_DATA_LOC)
    |=> $stable(regs_q.data))
    else $error("data register changed with no operation");

  a_done_rise_end: assert property (
    $rose(write_done_flag_q) |-> $fell(regs_q.ctrl[NVAC_CB_WGO]))
    else $error("done flag set outside a write end");

endmodule // nvac_ctrl

`default_nettype wire

// >>> nvac_pkg.sv
// Constants and types for the nonvolatile byte access controller
package nvac_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int unsigned NVAC_DEPTH  = 64;
  localparam int unsigned NVAC_AW     = 6;
  localparam int unsigned NVAC_DW     = 8;

  // ----------------------------------------------------------------
  // Register locations: bit 8 is the sector, bits 7:0 the offset
  // ----------------------------------------------------------------
  localparam logic [8:0] NVAC_ADDR_LOC = 9'h046;
  localparam logic [8:0] NVAC_DATA_LOC = 9'h047;
  localparam logic [8:0] NVAC_CTRL_LOC = 9'h140;

  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned NVAC_CB_WEN   = 3;
  localparam int unsigned NVAC_CB_WGO   = 2;
  localparam int unsigned NVAC_CB_REN   = 1;
  localparam int unsigned NVAC_CB_RGO   = 0;
  localparam logic [3:0]  NVAC_CTRL_RST = 4'h0;
  localparam logic [5:0]  NVAC_ADDR_RST = 6'h00;
  localparam logic [7:0]  NVAC_DATA_RST = 8'h00;
  localparam logic [7:0]  NVAC_CELL_RST = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned NVAC_CLK_NS   = 10;
  localparam int unsigned NVAC_RD_NS    = 20;
  localparam logic [3:0]  NVAC_RD_CYC   = 4'((NVAC_RD_NS + NVAC_CLK_NS - 1) / NVAC_CLK_NS);
  localparam logic [3:0]  NVAC_WR_TICKS = 4'h4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    NVAC_IDLE  = 2'b00,
    NVAC_READ  = 2'b01,
    NVAC_WRITE = 2'b10
  } nvac_state_t;

  typedef struct packed {
    logic       we;
    logic [8:0] loc;
    logic [7:0] wdata;
  } nvac_sfr_req_t;

  typedef struct packed {
    logic [NVAC_DEPTH-1:0][NVAC_DW-1:0] mem;
    nvac_state_t                        st;
    logic [3:0]                         cnt;
    logic [NVAC_AW-1:0]                 addr;
    logic [NVAC_DW-1:0]                 data;
    logic [3:0]                         ctrl;
    logic                               done;
    logic [7:0]                         rdata;
    logic                               busy;
  } nvac_regs_t;

endpackage

// >>> nvac_core_model.sv
// Core-side model: register accesses and slow timer ticks
`timescale 1ns/100ps
`default_nettype none
module nvac_core_model
  import nvac_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic [7:0]    rdata,
  output var  nvac_sfr_req_t sfr_req,
  output wire logic          slow_tick
);
  logic [2:0] div_q = 3'h0;

  initial sfr_req = '0;
  // Slow timer runs from time zero, stable before any write
  always @(negedge clk_sys) div_q <= div_q + 3'h1;
  assign slow_tick = (div_q == 3'h6);

  // One write per call; enable and start share a write when d sets both bits
  task automatic wr(input logic [8:0] l, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_req <= '{we: 1'b1, loc: l, wdata: d};
    @(negedge clk_sys);
    sfr_req.we <= 1'b0;
  endtask

  // Enable then start in two consecutive cycles
  task automatic wr_pair(input logic [8:0] l, input logic [7:0] d0, input logic [7:0] d1);
    @(negedge clk_sys);
    sfr_req <= '{we: 1'b1, loc: l, wdata: d0};
    @(negedge clk_sys);
    sfr_req <= '{we: 1'b1, loc: l, wdata: d1};
    @(negedge clk_sys);
    sfr_req.we <= 1'b0;
  endtask

  // Readback only, never disturbs an ongoing write
  task automatic rd(input logic [8:0] l, output logic [7:0] d);
    @(negedge clk_sys);
    sfr_req <= '{we: 1'b0, loc: l, wdata: ~sfr_req.wdata};
    @(negedge clk_sys);
    d = rdata;
  endtask
endmodule // nvac_core_model
`default_nettype wire

// >>> test_nvac_ctrl.sv
// Self-checking bench for the nonvolatile byte access controller
`timescale 1ns/100ps
`default_nettype none
module test_nvac_ctrl
  import nvac_pkg::*;
;
  logic          clk_sys = 1'b0;
  logic          reset_n = 1'b0;
  logic          done_clr = 1'b0;
  nvac_sfr_req_t sfr_req;
  logic          slow_tick;
  logic [7:0]    rdata;
  logic          flag;
  logic          busy;
  logic [7:0]    v;
  int            miscompares = 0;
  int            cmp_count = 0;

  always #5 clk_sys = ~clk_sys;

  nvac_core_model i_core (.clk_sys(clk_sys), .rdata(rdata), .sfr_req(sfr_req),
                          .slow_tick(slow_tick));
  nvac_ctrl i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .sfr_req(sfr_req),
                   .slow_tick(slow_tick), .done_clr(done_clr), .sfr_rdata_q(rdata),
                   .write_done_flag_q(flag), .busy_q(busy));

  // ----------------------------------------------------------------
  // Checks and scenarios
  // ----------------------------------------------------------------
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic rck(input string n, input logic [8:0] l, input logic [7:0] e);
    i_core.rd(l, v);
    chk8(n, e, v);
  endtask
  // Polls until the operation ends; nothing else is issued meanwhile
  task automatic wait_clr(input logic [7:0] m);
    for (int i = 0; i < 40; i++) begin
      i_core.rd(NVAC_CTRL_LOC, v);
      if ((v & m) === 8'h00) return;
    end
    miscompares++;
    $display("ERROR poll expected %h seen %h", 8'h00, v & m);
  endtask
  task automatic t_reset;
    rck("addr", NVAC_ADDR_LOC, 8'h00);
    rck("data", NVAC_DATA_LOC, 8'h00);
    rck("ctrl", NVAC_CTRL_LOC, 8'h00);
    rck("unmapped", 9'h040, 8'h00);
    chk1("busy", 1'b0, busy);
  endtask
  task automatic t_fields;
    i_core.wr(NVAC_ADDR_LOC, 8'hFF);
    rck("addr", NVAC_ADDR_LOC, 8'h3F);
    i_core.wr(NVAC_CTRL_LOC, 8'hF0);
    rck("ctrl", NVAC_CTRL_LOC, 8'h00);
    i_core.wr(NVAC_DATA_LOC, 8'h5A);
    rck("data", NVAC_DATA_LOC, 8'h5A);
  endtask
  task automatic t_refuse;
    i_core.wr(NVAC_CTRL_LOC, 8'h04);
    rck("ctrl", NVAC_CTRL_LOC, 8'h00);
    i_core.wr(NVAC_CTRL_LOC, 8'h01);
    rck("ctrl", NVAC_CTRL_LOC, 8'h00);
    chk1("busy", 1'b0, busy);
    chk1("flag", 1'b0, flag);
  endtask
  task automatic t_write;
    i_core.wr(NVAC_ADDR_LOC, 8'h3F);
    i_core.wr(NVAC_DATA_LOC, 8'hA5);
    i_core.wr_pair(NVAC_CTRL_LOC, 8'h08, 8'h0C);
    rck("ctrl", NVAC_CTRL_LOC, 8'h0C);
    chk1("busy", 1'b1, busy);
    wait_clr(8'h04);
    chk8("ctrl", 8'h08, v);
    repeat (5) @(negedge clk_sys);
    chk1("flag", 1'b1, flag);
    done_clr = 1'b1;
    @(negedge clk_sys) done_clr = 1'b0;
    chk1("flag", 1'b0, flag);
    i_core.wr(NVAC_CTRL_LOC, 8'h00);
  endtask
  task automatic t_read;
    i_core.wr(NVAC_DATA_LOC, 8'h00);
    i_core.wr(NVAC_CTRL_LOC, 8'h02);
    i_core.wr(NVAC_ADDR_LOC, 8'h3F);
    i_core.wr(NVAC_CTRL_LOC, 8'h03);
    wait_clr(8'h01);
    chk8("ctrl", 8'h02, v);
    rck("data", NVAC_DATA_LOC, 8'hA5);
    repeat (4) @(negedge clk_sys);
    rck("data", NVAC_DATA_LOC, 8'hA5);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) reset_n = 1'b1;
    t_reset();
    t_fields();
    t_refuse();
    t_write();
    t_read();
    report_and_stop();
  end
  initial begin
    #50000;
    miscompares++;
    report_and_stop();
  end
endmodule // test_nvac_ctrl
`default_nettype wire
